// File: clock_ctrl_pkg.sv
/*
  Shared constants and carrier types for the clock gating and divider control block.
  Assumes every clock source is seen as a sampled level in the single system clock domain.
*/
// What this block does
// [R1] One root gate per bank, built inside that bank's periphery clock multiplexer.
// [R2] Each bank clock may pass straight, pass through the root gate, or be divided.
// [R3] A sector has 32 sector clocks, each with a gate and a bypass.
// [R4] Sector gates take core enables; at most eight distinct enables per sector.
// [R5] A sector gate samples its enable at the next rising input clock edge.
// [R6] The gate holds its enable while the input clock is high, so no glitches.
// [R7] Sector clocks reach only their own sector; each sector carries its own gates.
// [R8] Sector gating is cycle exact; the enable path is plain synchronous logic.
// [R9] Each PLL counter gate enable is synchronised into that counter's clock.
// [R10] Core logic must not expect a fixed delay from PLL gate enable change.
// [R11] The root gate serves one of seven PLL counters; counter gates serve all.
// [R12] The cluster register enable is data feedback holding the value; clock keeps running.
// [R13] Divider outputs never feed the bank's own root gate, only routed sector gates.
// [R14] The divider gives the input clock, the clock over two and over four.
// [R15] All three divider outputs rise together.
// [R16] Each sector side has 64 wires in pairs; one wire of a pair driven.
// [R17] Core clocks enter routing directly, skipping the periphery multiplexer.
// [R18] A disabled gate holds its output low; enabling starts with a full high phase.
// [R19] Divide-by-two and divide-by-four stages clear together, aligned to the pass output.
package clock_ctrl_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int PLL_COUNTERS = 7;
  localparam int BANK_SOURCES = 4;
  localparam int NUM_BANKS = 2;
  localparam int CORE_CLOCKS = 4;
  localparam int SECTOR_CLOCKS = 32;
  localparam int SECTOR_ENABLES = 8;
  localparam int ROUTE_WIRES = 64;
  localparam int ROUTE_PAIRS = ROUTE_WIRES / 2;
  localparam int CLUSTER_WIDTH = 8;
  localparam int BANK_SRC_TOTAL = PLL_COUNTERS + BANK_SOURCES;
  localparam int ROUTE_SRC_TOTAL = NUM_BANKS + CORE_CLOCKS;
  localparam int DIV_OUTPUTS = 3;

  ////////////////////////////////////////////////////////////////////////////////
  // field positions of the three divider outputs
  localparam int DIV_POS_PASS = 0;
  localparam int DIV_POS_HALF = 1;
  localparam int DIV_POS_QUARTER = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic RESET_LOW = 1'h0;
  localparam logic [CLUSTER_WIDTH-1:0] CLUSTER_RESET = 8'h00;
  localparam logic [3:0] SRC_SEL_RESET = 4'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // modes and carriers
  typedef enum logic [1:0] {MUX_PASS, MUX_GATE, MUX_DIVIDE} mux_mode_t;
  typedef enum logic [1:0] {DIV_BY1, DIV_BY2, DIV_BY4} div_sel_t;

  typedef struct packed {
    mux_mode_t mode;
    div_sel_t div_sel;
    logic [3:0] src_sel;
    logic [2:0] root_pll_sel;
    logic root_en;
  } bank_cfg_t;

  typedef struct packed {
    logic [2:0] src_sel;
    logic [2:0] en_sel;
    logic bypass;
  } sclk_cfg_t;

  typedef struct packed {
    logic req;
    logic dir_b;
  } route_cfg_t;

endpackage

// File: clock_gate_cell.sv
/*
  Glitch-free gate cell: holds its enable while the clock level is high.
  Assumes clk_level_i and enable_i are already in the clk_i domain.
*/
`timescale 1ns/1ps
module clock_gate_cell (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clk_level_i,
  input wire logic enable_i,
  output logic gated_o
);

  logic held_en;

  ////////////////////////////////////////////////////////////////////////////////
  // enable follows only while the clock is low, so it is frozen on each rise
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      held_en <= clock_ctrl_pkg::RESET_LOW;
    end
    else if (!clk_level_i)
    begin
      held_en <= enable_i; // see [R6] see [R5]
    end
  end

  // gated level: low while disabled, whole high phases otherwise
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gated_o <= clock_ctrl_pkg::RESET_LOW;
    end
    else
    begin
      gated_o <= clk_level_i & held_en; // see [R18] see [R8]
    end
  end

endmodule // clock_gate_cell

// File: clock_gate_and_divider_control.sv
/*
  Clock control for one sector and its feeding banks: PLL counter gates, periphery
  clock multiplexers with root gate and divider, sector clock gates, routing pair
  drive control and the logic cluster register enable.
  Assumes clock sources arrive as levels from outside and are oversampled by clk_i;
  core enables, core clocks and configuration come from logic on clk_i.
*/
`timescale 1ns/1ps
module clock_gate_and_divider_control #(
  parameter int NUM_PLL = clock_ctrl_pkg::PLL_COUNTERS,
  parameter int NUM_BANK = clock_ctrl_pkg::NUM_BANKS,
  parameter int NUM_BANK_SRC = clock_ctrl_pkg::BANK_SOURCES,
  parameter int NUM_CORE = clock_ctrl_pkg::CORE_CLOCKS,
  parameter int NUM_SCLK = clock_ctrl_pkg::SECTOR_CLOCKS,
  parameter int NUM_EN = clock_ctrl_pkg::SECTOR_ENABLES,
  parameter int NUM_PAIRS = clock_ctrl_pkg::ROUTE_PAIRS,
  parameter int LC_WIDTH = clock_ctrl_pkg::CLUSTER_WIDTH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [NUM_PLL-1:0] pll_clk_i,
  input wire logic [NUM_PLL-1:0] pll_gate_en_i,
  input wire logic [NUM_BANK*NUM_BANK_SRC-1:0] bank_src_clk_i,
  input wire clock_ctrl_pkg::bank_cfg_t [NUM_BANK-1:0] bank_cfg_i,
  input wire logic [NUM_CORE-1:0] core_clk_i,
  input wire clock_ctrl_pkg::sclk_cfg_t [NUM_SCLK-1:0] sclk_cfg_i,
  input wire logic [NUM_EN-1:0] sector_en_i,
  input wire clock_ctrl_pkg::route_cfg_t [NUM_PAIRS-1:0] route_cfg_i,
  input wire logic [LC_WIDTH-1:0] lc_d_i,
  input wire logic lc_ce_i,
  output logic [NUM_PLL-1:0] pll_clk_o,
  output logic [NUM_BANK-1:0] bank_clk_o,
  output logic [NUM_BANK*clock_ctrl_pkg::DIV_OUTPUTS-1:0] bank_div_o,
  output logic [NUM_SCLK-1:0] sclk_o,
  output logic [NUM_PAIRS-1:0] route_a_oe_o,
  output logic [NUM_PAIRS-1:0] route_b_oe_o,
  output logic [LC_WIDTH-1:0] lc_q_o
);

  localparam int DIVN = clock_ctrl_pkg::DIV_OUTPUTS;
  localparam int SRCN = NUM_PLL + NUM_BANK_SRC;
  localparam int ROUTEN = NUM_BANK + NUM_CORE;

  logic [NUM_PLL-1:0] pll_meta;
  logic [NUM_PLL-1:0] pll_sync;
  logic [NUM_PLL-1:0] pll_prev;
  logic [NUM_PLL-1:0] pll_en_s1;
  logic [NUM_PLL-1:0] pll_en_s2;
  logic [NUM_PLL-1:0] pll_gated;
  logic [NUM_BANK*NUM_BANK_SRC-1:0] bank_meta;
  logic [NUM_BANK*NUM_BANK_SRC-1:0] bank_sync;
  logic [ROUTEN-1:0] route_src;

  ////////////////////////////////////////////////////////////////////////////////
  // PLL counter gates: each enable is carried into its counter's own clock
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pll_meta <= '0;
      pll_sync <= '0;
      pll_prev <= '0;
    end
    else
    begin
      pll_meta <= pll_clk_i;
      pll_sync <= pll_meta;
      pll_prev <= pll_sync;
    end
  end

  genvar p;
  generate
    for (p = 0; p < NUM_PLL; p++)
    begin : g_pll
      // two stages clocked by the counter's own rising edges: delay depends on phase
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          pll_en_s1[p] <= clock_ctrl_pkg::RESET_LOW;
          pll_en_s2[p] <= clock_ctrl_pkg::RESET_LOW;
        end
        else if (pll_sync[p] && !pll_prev[p])
        begin
          pll_en_s1[p] <= pll_gate_en_i[p]; // see [R9] see [R10]
          pll_en_s2[p] <= pll_en_s1[p]; // see [R9]
        end
      end

      clock_gate_cell u_pll_gate (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clk_level_i(pll_sync[p]),
        .enable_i(pll_en_s2[p]),
        .gated_o(pll_gated[p])
      ); // see [R11]
    end
  endgenerate

  assign pll_clk_o = pll_gated;

  ////////////////////////////////////////////////////////////////////////////////
  // bank clock pins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bank_meta <= '0;
      bank_sync <= '0;
    end
    else
    begin
      bank_meta <= bank_src_clk_i;
      bank_sync <= bank_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // periphery clock multiplexers, one per bank
  genvar b;
  generate
    for (b = 0; b < NUM_BANK; b++)
    begin : g_bank
      logic [SRCN-1:0] src_all;
      logic sel_lvl;
      logic root_lvl;
      logic root_out;
      logic pass_q;
      logic half_q;
      logic quarter_q;
      logic [3:0] last_sel;
      logic div_clear;
      logic next_bank;

      assign src_all = {bank_sync[b*NUM_BANK_SRC +: NUM_BANK_SRC], pll_gated};

      always_comb
      begin
        sel_lvl = clock_ctrl_pkg::RESET_LOW;
        if (int'(bank_cfg_i[b].src_sel) < SRCN)
        begin
          sel_lvl = src_all[bank_cfg_i[b].src_sel];
        end
      end

      // root gate takes one PLL counter only, never the divider output
      always_comb
      begin
        root_lvl = clock_ctrl_pkg::RESET_LOW;
        if (int'(bank_cfg_i[b].root_pll_sel) < NUM_PLL)
        begin
          root_lvl = pll_gated[bank_cfg_i[b].root_pll_sel]; // see [R11] see [R13]
        end
      end

      clock_gate_cell u_root_gate (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clk_level_i(root_lvl),
        .enable_i(bank_cfg_i[b].root_en),
        .gated_o(root_out)
      ); // see [R1]

      // a source change restarts both stages so they stay in step
      assign div_clear = (bank_cfg_i[b].src_sel != last_sel); // see [R19]

      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          last_sel <= clock_ctrl_pkg::SRC_SEL_RESET;
        end
        else
        begin
          last_sel <= bank_cfg_i[b].src_sel;
        end
      end

      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          pass_q <= clock_ctrl_pkg::RESET_LOW;
        end
        else
        begin
          pass_q <= sel_lvl; // see [R14]
        end
      end

      // stages advance on the same edge that raises the pass output
      always_ff @(posedge clk_i)
      begin
        if (rst_i || div_clear)
        begin
          half_q <= clock_ctrl_pkg::RESET_LOW; // see [R19]
          quarter_q <= clock_ctrl_pkg::RESET_LOW; // see [R19]
        end
        else if (sel_lvl && !pass_q)
        begin
          half_q <= !half_q; // see [R14] see [R15]
          if (!half_q)
          begin
            quarter_q <= !quarter_q; // see [R15]
          end
        end
      end

      always_comb
      begin
        next_bank = pass_q;
        case (bank_cfg_i[b].mode)
          clock_ctrl_pkg::MUX_PASS:
          begin
            next_bank = pass_q; // see [R2]
          end
          clock_ctrl_pkg::MUX_GATE:
          begin
            next_bank = root_out; // see [R2]
          end
          clock_ctrl_pkg::MUX_DIVIDE:
          begin
            case (bank_cfg_i[b].div_sel)
              clock_ctrl_pkg::DIV_BY2: next_bank = half_q; // see [R2]
              clock_ctrl_pkg::DIV_BY4: next_bank = quarter_q;
              default: next_bank = pass_q;
            endcase
          end
          default:
          begin
            next_bank = clock_ctrl_pkg::RESET_LOW;
          end
        endcase
      end

      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          bank_clk_o[b] <= clock_ctrl_pkg::RESET_LOW;
          bank_div_o[b*DIVN +: DIVN] <= '0;
        end
        else
        begin
          bank_clk_o[b] <= next_bank;
          bank_div_o[b*DIVN + clock_ctrl_pkg::DIV_POS_PASS] <= pass_q; // see [R15]
          bank_div_o[b*DIVN + clock_ctrl_pkg::DIV_POS_HALF] <= half_q;
          bank_div_o[b*DIVN + clock_ctrl_pkg::DIV_POS_QUARTER] <= quarter_q;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // routing sources: bank outputs, and core clocks that skip the bank mux
  assign route_src = {core_clk_i, bank_clk_o}; // see [R17] see [R13]

  ////////////////////////////////////////////////////////////////////////////////
  // sector clocks: this sector's own gates, shared pool of core enables
  genvar s;
  generate
    for (s = 0; s < NUM_SCLK; s++)
    begin : g_sclk
      logic lvl;
      logic lvl_q;
      logic en;
      logic gated;

      always_comb
      begin
        lvl = clock_ctrl_pkg::RESET_LOW;
        if (int'(sclk_cfg_i[s].src_sel) < ROUTEN)
        begin
          lvl = route_src[sclk_cfg_i[s].src_sel]; // see [R7]
        end
      end

      always_comb
      begin
        en = clock_ctrl_pkg::RESET_LOW;
        if (int'(sclk_cfg_i[s].en_sel) < NUM_EN)
        begin
          en = sector_en_i[sclk_cfg_i[s].en_sel]; // see [R4]
        end
      end

      clock_gate_cell u_sclk_gate (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clk_level_i(lvl),
        .enable_i(en),
        .gated_o(gated)
      ); // see [R3] see [R5] see [R8]

      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          lvl_q <= clock_ctrl_pkg::RESET_LOW;
          sclk_o[s] <= clock_ctrl_pkg::RESET_LOW;
        end
        else
        begin
          lvl_q <= lvl;
          sclk_o[s] <= sclk_cfg_i[s].bypass ? lvl_q : gated; // see [R3]
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // routing pairs: never both wires of a pair driven
  genvar w;
  generate
    for (w = 0; w < NUM_PAIRS; w++)
    begin : g_pair
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          route_a_oe_o[w] <= clock_ctrl_pkg::RESET_LOW;
          route_b_oe_o[w] <= clock_ctrl_pkg::RESET_LOW;
        end
        else
        begin
          route_a_oe_o[w] <= route_cfg_i[w].req & !route_cfg_i[w].dir_b; // see [R16]
          route_b_oe_o[w] <= route_cfg_i[w].req & route_cfg_i[w].dir_b; // see [R16]
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // logic cluster register: enable recirculates data, clock never stops
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lc_q_o <= clock_ctrl_pkg::CLUSTER_RESET;
    end
    else
    begin
      lc_q_o <= lc_ce_i ? lc_d_i : lc_q_o; // see [R12]
    end
  end

endmodule // clock_gate_and_divider_control

// File: clock_ctrl_assertions.sv
/*
  Checker for the clock control block: routing pair drive, cluster register,
  PLL counter gates and divider edge alignment.
  Assumes it is bound to the block's top module and sees only its ports.
*/
`timescale 1ns/1ps
module clock_ctrl_assertions #(
  parameter int NUM_PLL = 7,
  parameter int NUM_BANK = 2,
  parameter int NUM_PAIRS = 32,
  parameter int LC_WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [NUM_PLL-1:0] pll_clk_i,
  input wire logic [NUM_PLL-1:0] pll_gate_en_i,
  input wire clock_ctrl_pkg::route_cfg_t [NUM_PAIRS-1:0] route_cfg_i,
  input wire logic [LC_WIDTH-1:0] lc_d_i,
  input wire logic lc_ce_i,
  input wire logic [NUM_PLL-1:0] pll_clk_o,
  input wire logic [NUM_BANK*clock_ctrl_pkg::DIV_OUTPUTS-1:0] bank_div_o,
  input wire logic [NUM_PAIRS-1:0] route_a_oe_o,
  input wire logic [NUM_PAIRS-1:0] route_b_oe_o,
  input wire logic [LC_WIDTH-1:0] lc_q_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  //////////////////////////////////////////////////////////////////////////////
  logic [NUM_PAIRS-1:0] want_a;
  logic [NUM_PAIRS-1:0] want_b;
  logic [5:0] off_cnt;

  always_comb
  begin
    for (int p = 0; p < NUM_PAIRS; p++)
    begin
      want_a[p] = route_cfg_i[p].req & ~route_cfg_i[p].dir_b;
      want_b[p] = route_cfg_i[p].req & route_cfg_i[p].dir_b;
    end
  end

  // cycles that counter 0 has been held disabled, saturating
  always_ff @(posedge clk_i)
  begin
    if (rst_i || pll_gate_en_i[0])
      off_cnt <= 6'h0;
    else if (off_cnt != 6'h3f)
      off_cnt <= off_cnt + 6'h1;
  end

  //////////////////////////////////////////////////////////////////////////////
  pair_exclusive_a: assert property ((route_a_oe_o & route_b_oe_o) == '0)
    else $error("both wires of a routing pair driven");
  wire_a_drive_a: assert property (!$past(rst_i) |-> route_a_oe_o == $past(want_a))
    else $error("wire a drive does not follow its request");
  wire_b_drive_a: assert property (!$past(rst_i) |-> route_b_oe_o == $past(want_b))
    else $error("wire b drive does not follow its request");
  cluster_load_a: assert property (lc_ce_i |=> lc_q_o == $past(lc_d_i))
    else $error("cluster register missed a load");
  cluster_hold_a: assert property (!lc_ce_i |=> $stable(lc_q_o))
    else $error("cluster register changed while disabled");
  pll_mask_a: assert property (
    (pll_clk_o & ~($past(pll_clk_i, 2) | $past(pll_clk_i, 3))) == '0)
    else $error("gated counter high while its source was low");
  pll_off_a: assert property (off_cnt >= 6'h28 |-> !pll_clk_o[0])
    else $error("disabled counter still toggling");
  quarter_edge_a: assert property (
    $rose(bank_div_o[2]) |-> $rose(bank_div_o[1]) && $rose(bank_div_o[0]))
    else $error("quarter output rose out of line");
  half_edge_a: assert property ($rose(bank_div_o[1]) |-> $rose(bank_div_o[0]))
    else $error("half output rose out of line");
endmodule // clock_ctrl_assertions

bind clock_gate_and_divider_control clock_ctrl_assertions #(
  .NUM_PLL(NUM_PLL),
  .NUM_BANK(NUM_BANK),
  .NUM_PAIRS(NUM_PAIRS),
  .LC_WIDTH(LC_WIDTH)
) clock_ctrl_assertions_inst (
  .clk_i, .rst_i, .pll_clk_i, .pll_gate_en_i, .route_cfg_i, .lc_d_i, .lc_ce_i,
  .pll_clk_o, .bank_div_o, .route_a_oe_o, .route_b_oe_o, .lc_q_o
);

// File: core_enable_model.sv
/*
  Core user logic model: free running core clocks and gate enables.
  Assumes commands from the bench are settled before each falling edge.
*/
`timescale 1ns/1ps
module core_enable_model (
  input wire logic clk_i,
  input wire logic [7:0] sector_cmd_i,
  input wire logic [6:0] pll_cmd_i,
  output logic [3:0] core_clk_o = 4'h0,
  output logic [7:0] sector_en_o = 8'h0,
  output logic [6:0] pll_gate_en_o = 7'h0
);
  // core clock k has a period of 2 to the k+1 system cycles
  always @(negedge clk_i)
  begin
    core_clk_o <= core_clk_o + 4'h1;
    sector_en_o <= sector_cmd_i;
    pll_gate_en_o <= pll_cmd_i;
  end
endmodule // core_enable_model

// File: clock_gate_and_divider_control_tb.sv
/*
  Self-checking bench for the clock control block.
  Assumes the checker is bound by its own file and the core model drives the enables.
*/
`timescale 1ns/1ps
module clock_gate_and_divider_control_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [6:0] pll_clk_i = 7'h0;
  logic [6:0] pll_cmd = 7'h0;
  logic [6:0] pll_gate_en_i;
  logic [7:0] bank_src_clk_i = 8'h0;
  clock_ctrl_pkg::bank_cfg_t [1:0] bank_cfg_i = '0;
  logic [3:0] core_clk_i;
  clock_ctrl_pkg::sclk_cfg_t [31:0] sclk_cfg_i = '0;
  logic [7:0] sector_cmd = 8'h0;
  logic [7:0] sector_en_i;
  clock_ctrl_pkg::route_cfg_t [31:0] route_cfg_i = '0;
  logic [7:0] lc_d_i = 8'h0;
  logic lc_ce_i = 1'b0;
  logic [6:0] pll_clk_o;
  logic [1:0] bank_clk_o;
  logic [5:0] bank_div_o;
  logic [31:0] sclk_o, route_a_oe_o, route_b_oe_o;
  logic [7:0] lc_q_o, exp_q;
  logic [3:0] c1, c2;
  logic [7:0] tick = 8'h0;
  int bad_count = 0;
  int compares = 0;
  int rises[5];

  clock_gate_and_divider_control clock_gate_and_divider_control_inst (
    .clk_i, .rst_i, .pll_clk_i, .pll_gate_en_i, .bank_src_clk_i, .bank_cfg_i, .core_clk_i,
    .sclk_cfg_i, .sector_en_i, .route_cfg_i, .lc_d_i, .lc_ce_i, .pll_clk_o, .bank_clk_o,
    .bank_div_o, .sclk_o, .route_a_oe_o, .route_b_oe_o, .lc_q_o
  );
  core_enable_model core_enable_model_inst (
    .clk_i, .sector_cmd_i(sector_cmd), .pll_cmd_i(pll_cmd), .core_clk_o(core_clk_i),
    .sector_en_o(sector_en_i), .pll_gate_en_o(pll_gate_en_i)
  );

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #2.5 clk_i = ~clk_i;
  end

  // PLL counters of period 8 and bank sources of period 4
  always @(negedge clk_i)
  begin
    tick <= tick + 8'h1;
    pll_clk_i <= {7{tick[2]}};
    bank_src_clk_i <= {8{tick[1]}};
  end

  always @(posedge clk_i)
  begin
    c1 <= core_clk_i;
    c2 <= c1;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  function automatic logic [31:0] want(input logic to_b);
    for (int p = 0; p < 32; p++)
      want[p] = route_cfg_i[p].req & (route_cfg_i[p].dir_b == to_b);
  endfunction

  function automatic logic [31:0] sector_want(input logic [7:0] en);
    for (int i = 0; i < 32; i++)
      sector_want[i] = c2[i % 4] & (sclk_cfg_i[i].bypass | en[i % 8]);
  endfunction

  function automatic logic near(input int a, input int b, input int tol);
    return (a + tol >= b) && (a <= b + tol);
  endfunction

  // both banks get the same sources and settings except the random root PLL select, and all counters match, so bank 1 must track bank 0
  task automatic count_rises(input int n);
    logic [4:0] prev;
    logic [4:0] cur;
    rises = '{default: 0};
    prev = {sclk_o[0], bank_div_o[2:0], bank_clk_o[0]};
    repeat (n)
    begin
      @(negedge clk_i);
      cur = {sclk_o[0], bank_div_o[2:0], bank_clk_o[0]};
      check({bank_clk_o[1], bank_div_o[5:3]}, {bank_clk_o[0], bank_div_o[2:0]});
      for (int k = 0; k < 5; k++)
        rises[k] += int'(cur[k] & ~prev[k]);
      prev = cur;
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #20us;
    bad_count++;
    summarize();
  end

  initial
  begin
    logic [6:0] pmask;
    int rs;
    int e;
    rs = $urandom(32'h3460_1300);
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
    exp_q = 8'h0;
    // first pass drives every pair to its b wire and loads the cluster
    for (int t = 0; t < 61; t++)
    begin
      @(negedge clk_i);
      if (t > 0)
      begin
        if (lc_ce_i)
          exp_q = lc_d_i;
        check(route_a_oe_o, want(1'b0));
        check(route_b_oe_o, want(1'b1));
        check(lc_q_o, exp_q);
      end
      else
      begin
        // first edge after reset: every gated and divided output still low
        check({pll_clk_o, bank_clk_o, bank_div_o, sclk_o, lc_q_o}, 64'h0);
      end
      foreach (route_cfg_i[p])
        route_cfg_i[p] = (t == 0) ? 2'b11 : 2'($urandom());
      lc_d_i = 8'($urandom());
      lc_ce_i = (t == 0) | 1'($urandom_range(1));
    end
    $display("test routing and cluster done");
    foreach (sclk_cfg_i[i])
      sclk_cfg_i[i] = {3'(2 + i % 4), 3'(i % 8), 1'b0};
    for (int t = 0; t < 8; t++)
    begin
      sector_cmd = (t < 2) ? {8{t[0]}} : 8'($urandom());
      foreach (sclk_cfg_i[i])
        sclk_cfg_i[i].bypass = t[2];
      repeat (40) @(negedge clk_i);
      repeat (16)
      begin
        @(negedge clk_i);
        check(sclk_o, sector_want(sector_cmd));
      end
    end
    $display("test sector gates done");
    for (int t = 0; t < 4; t++)
    begin
      pll_cmd = (t < 2) ? {7{t[0]}} : 7'($urandom());
      // long enough for the variable synchroniser delay
      repeat (40) @(negedge clk_i);
      pmask = 7'h0;
      repeat (16)
      begin
        @(negedge clk_i);
        pmask |= pll_clk_o;
      end
      check(pmask, pll_cmd);
    end
    $display("test counter gates done");
    pll_cmd = 7'h7f;
    // sector clock 0 takes bank 0 output through its gate, enable held on
    sector_cmd = 8'hff;
    sclk_cfg_i[0] = {3'h0, 3'h0, 1'b0};
    for (int t = 0; t < 6; t++)
    begin
      foreach (bank_cfg_i[b])
        bank_cfg_i[b] = {t == 0 ? clock_ctrl_pkg::MUX_PASS : t < 3 ? clock_ctrl_pkg::MUX_GATE :
          clock_ctrl_pkg::MUX_DIVIDE, clock_ctrl_pkg::div_sel_t'(t < 3 ? 0 : t - 3), 4'h7,
          3'($urandom_range(6)), 1'(t)};
      e = (t == 2) ? 0 : (t == 1) ? 8 : 16 >> (t < 3 ? 0 : t - 3);
      repeat (16) @(negedge clk_i);
      count_rises(64);
      check(near(rises[0], e, int'(e > 0)), 1'b1);
      check(near(rises[4], rises[0], 1), 1'b1);
      if (t == 5)
      begin
        check(near(rises[2] * 2, rises[1], 1), 1'b1);
        check(near(rises[3] * 4, rises[1], 3), 1'b1);
      end
    end
    $display("test periphery multiplexer done");
    summarize();
  end
endmodule // clock_gate_and_divider_control_tb
